// ===== design/stepper_defines.vh
/*
 constants for the stepper run control block: register offsets, field
 positions, reset values and timing counts.
 assumes a 10 MHz system clock and an 8-bit register port.
*/
`ifndef STEPPER_DEFINES_VH
`define STEPPER_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_FWD_COUNT_LOW   8'h12
`define OFS_FWD_COUNT_HIGH  8'h13
`define OFS_REV_COUNT_LOW   8'h14
`define OFS_REV_COUNT_HIGH  8'h15
`define OFS_FWD_PW_LOW      8'h16
`define OFS_FWD_PW_HIGH     8'h17
`define OFS_REV_PW_LOW      8'h18
`define OFS_REV_PW_HIGH     8'h19
`define OFS_RUN_CONTROL     8'h1a

// ----------------------------------------------------------------
// motor_run_control fields
// ----------------------------------------------------------------
`define CTL_RUN_BIT         7
`define CTL_RESTART_BIT     6
`define CTL_ESTOP_BIT       5
`define CTL_HOME_EN_BIT     4
`define CTL_HOME_POL_BIT    3
`define CTL_DIR_HI          1
`define CTL_DIR_LO          0
`define DIR_FWD             2'h0
`define DIR_REV             2'h1
`define DIR_FWD_THEN_REV    2'h2
`define DIR_REV_THEN_FWD    2'h3

// ----------------------------------------------------------------
// pulse width fields
// ----------------------------------------------------------------
`define PW_PRESCALE_HI      15
`define PW_PRESCALE_LO      13
`define PW_WIDTH_HI         12
`define PW_WIDTH_LO         0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE            8'h00
`define RST_WORD            16'h0000
`define RST_DIR             2'h0
`define RST_PHASE           4'h0
`define FIRST_PHASE         4'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS       100
`define TICK_PERIOD_NS      1000
`define TICK_CYCLES         (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_LAST           4'h9
`define BASE_UNIT_US        9'h003
`define MAX_UNITS           14'h2000

`endif

// ===== design/step_width_timer.v
/*
 phase period timer: free-running microsecond tick, a base unit of
 3 us times two to the prescale code, and a count of base units.
 assumes units is at least one and is steady between done pulses.
*/
`include "stepper_defines.vh"

module step_width_timer (
   input  wire        clk_i,
   input  wire        sys_rst_i,
   input  wire        run_i,
   input  wire        load_i,
   input  wire [2:0]  prescale_i,
   input  wire [13:0] units_i,
   output reg         done_o
);

   // ----------------------------------------------------------------
   // microsecond tick
   // ----------------------------------------------------------------
   reg  [3:0]  us_cnt;
   reg  [8:0]  base_cnt;
   reg  [13:0] unit_cnt;
   wire        us_tick;
   wire [8:0]  base_last;
   wire        unit_tick;

   assign us_tick   = (us_cnt == `TICK_LAST);
   assign base_last = (`BASE_UNIT_US << prescale_i) - 9'h001;
   assign unit_tick = us_tick && (base_cnt == base_last);

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         us_cnt <= 4'h0;
      end else if (us_tick) begin
         us_cnt <= 4'h0;
      end else begin
         us_cnt <= us_cnt + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // base unit and width counters
   // ----------------------------------------------------------------
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         base_cnt <= 9'h000;
         unit_cnt <= 14'h0000;
         done_o   <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (load_i || !run_i) begin
            base_cnt <= 9'h000;
            unit_cnt <= 14'h0000;
         end else if (us_tick) begin
            if (base_cnt == base_last) begin
               base_cnt <= 9'h000;
            end else begin
               base_cnt <= base_cnt + 9'h001;
            end
            if (unit_tick) begin
               if (unit_cnt + 14'h0001 >= units_i) begin
                  unit_cnt <= 14'h0000;
                  done_o   <= 1'b1;
               end else begin
                  unit_cnt <= unit_cnt + 14'h0001;
               end
            end
         end
      end
   end

endmodule

// ===== design/stepper_run_control.v
/*
 stepper step rate and run control: step count and pulse width
 registers, the motor run control register, run state machine and
 four wave-drive phase outputs.
 assumes an 8-bit register port from a bus slave on the same clock,
 single-cycle write and read strobes, and a home sense pin that is
 asynchronous to clk_i.
*/
// Contract
// - reverse step count is 16 bits at 14h/15h, read/write, reset zero.
// - forward rotation times each phase with the forward pulse width 16h/17h.
// - reverse rotation times each phase with the reverse pulse width 18h/19h.
// - top three width bits are prescale code scaling the 3 us base.
// - code 111 spans 384 us to 3145.728 ms from the 1 MHz tick.
// - phase width is prescale minimum times lower thirteen bits plus one.
// - ramping starts from and ends at the range maximum width. The code ramps down only for a normal stop; count end and home halt at once.
// - writing one to bit 7 of 1Ah starts a run.
// - bit 7 reads one while running, zero while stopped.
// - a start written during a run is ignored.
// - during a run only run, restart, emergency stop bits act.
// - bits 7 and 6 restart with new widths; bit 6 self-clears. The code reloads only the lower thirteen width bits, not the prescale code.
// - bit 5 stops at once, self-clears, bit 7 returns to zero.
// - write-only bit 4 enables home feature, reset zero.
// - write-only bit 3 picks the home level that blocks a start.
// - direction codes forward, reverse, forward-reverse, reverse-forward.
// - bit 2 is reserved and reads zero.
// - writing zero to bit 7 requests a normal stop; ignored when stopped.
// - no start if a used direction has a zero step count.
`include "stepper_defines.vh"

module stepper_run_control (
   input  wire       clk_i,
   input  wire       sys_rst_i,
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   input  wire       home_sense_input_i,
   input  wire       ramp_enable_i,
   output reg  [7:0] reg_rdata_o,
   output reg  [3:0] phase_o,
   output reg        motor_running_o,
   output reg        motor_reverse_o
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_RUN   = 3'b010;
   localparam [2:0] ST_DECEL = 3'b100;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function [13:0] width_units;
      input [15:0] pw;
      begin
         width_units = {1'b0, pw[`PW_WIDTH_HI:`PW_WIDTH_LO]} + 14'h0001;
      end
   endfunction

   function [13:0] ramp_toward;
      input [13:0] cur;
      input [13:0] tgt;
      reg   [13:0] stepv;
      begin
         stepv = (cur >> 3) + 14'h0001;
         if (cur > tgt) begin
            ramp_toward = (cur - tgt > stepv) ? cur - stepv : tgt;
         end else if (cur < tgt) begin
            ramp_toward = (tgt - cur > stepv) ? cur + stepv : tgt;
         end else begin
            ramp_toward = cur;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   reg  [15:0] forward_step_count;
   reg  [15:0] reverse_step_count;
   reg  [15:0] forward_pulse_width;
   reg  [15:0] reverse_pulse_width;
   reg  [1:0]  dir_sel;
   reg         home_en;
   reg         home_pol;
   reg         restart_pend;
   reg  [2:0]  state;
   reg         run_reverse;
   reg         second_leg;
   reg  [15:0] steps_left;
   reg  [13:0] cur_units;
   reg  [13:0] tgt_units;
   reg  [2:0]  prescale_run;
   reg         timer_load;
   reg         home_meta;
   reg         home_sync;

   wire        running;
   wire        phase_done;
   wire        ctl_wr;
   wire [1:0]  wr_dir;
   wire        wr_rev_first;
   wire        counts_ok;
   wire        home_block;
   wire        home_reached;
   wire [15:0] wr_pw;
   wire [15:0] run_pw;
   wire [15:0] other_pw;
   wire [15:0] other_count;
   wire        last_step;
   wire        reverse_leg_next;

   assign running      = (state != ST_IDLE);
   assign ctl_wr       = reg_wr_i && (reg_addr_i == `OFS_RUN_CONTROL);
   assign wr_dir       = reg_wdata_i[`CTL_DIR_HI:`CTL_DIR_LO];
   assign wr_rev_first = (wr_dir == `DIR_REV) || (wr_dir == `DIR_REV_THEN_FWD);
   assign wr_pw        = wr_rev_first ? reverse_pulse_width : forward_pulse_width;
   assign run_pw       = run_reverse ? reverse_pulse_width : forward_pulse_width;
   assign other_pw     = run_reverse ? forward_pulse_width : reverse_pulse_width;
   assign other_count  = run_reverse ? forward_step_count : reverse_step_count;
   assign last_step    = (steps_left == 16'h0001);
   assign reverse_leg_next = dir_sel[1] && !second_leg;

   assign counts_ok = (wr_dir == `DIR_FWD) ? (forward_step_count != `RST_WORD) :
                      (wr_dir == `DIR_REV) ? (reverse_step_count != `RST_WORD) :
                      ((forward_step_count != `RST_WORD) &&
                       (reverse_step_count != `RST_WORD));

   assign home_block   = reg_wdata_i[`CTL_HOME_EN_BIT] &&
                         (home_sync == reg_wdata_i[`CTL_HOME_POL_BIT]);
   assign home_reached = home_en && (home_sync == home_pol);

   // ----------------------------------------------------------------
   // home sense synchroniser
   // ----------------------------------------------------------------
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         home_meta <= 1'b0;
         home_sync <= 1'b0;
      end else begin
         home_meta <= home_sense_input_i;
         home_sync <= home_meta;
      end
   end

   // ----------------------------------------------------------------
   // phase timer
   // ----------------------------------------------------------------
   step_width_timer u_timer (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .run_i      (running),
      .load_i     (timer_load),
      .prescale_i (prescale_run),
      .units_i    (cur_units),
      .done_o     (phase_done)
   );

   // ----------------------------------------------------------------
   // parameter register writes
   // ----------------------------------------------------------------
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         forward_step_count  <= `RST_WORD;
         reverse_step_count  <= `RST_WORD;
         forward_pulse_width <= `RST_WORD;
         reverse_pulse_width <= `RST_WORD;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `OFS_FWD_COUNT_LOW:  forward_step_count[7:0]   <= reg_wdata_i;
            `OFS_FWD_COUNT_HIGH: forward_step_count[15:8]  <= reg_wdata_i;
            `OFS_REV_COUNT_LOW:  reverse_step_count[7:0]   <= reg_wdata_i;
            `OFS_REV_COUNT_HIGH: reverse_step_count[15:8]  <= reg_wdata_i;
            `OFS_FWD_PW_LOW:     forward_pulse_width[7:0]  <= reg_wdata_i;
            `OFS_FWD_PW_HIGH:    forward_pulse_width[15:8] <= reg_wdata_i;
            `OFS_REV_PW_LOW:     reverse_pulse_width[7:0]  <= reg_wdata_i;
            `OFS_REV_PW_HIGH:    reverse_pulse_width[15:8] <= reg_wdata_i;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // run control state machine
   // ----------------------------------------------------------------
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dir_sel         <= `RST_DIR;
         home_en         <= 1'b0;
         home_pol        <= 1'b0;
         restart_pend    <= 1'b0;
         state           <= ST_IDLE;
         run_reverse     <= 1'b0;
         second_leg      <= 1'b0;
         steps_left      <= `RST_WORD;
         cur_units       <= `MAX_UNITS;
         tgt_units       <= `MAX_UNITS;
         prescale_run    <= 3'h0;
         timer_load      <= 1'b0;
         phase_o         <= `RST_PHASE;
         motor_running_o <= 1'b0;
         motor_reverse_o <= 1'b0;
      end else begin
         timer_load <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (ctl_wr) begin
                  dir_sel  <= wr_dir;
                  home_en  <= reg_wdata_i[`CTL_HOME_EN_BIT];
                  home_pol <= reg_wdata_i[`CTL_HOME_POL_BIT];
                  if (reg_wdata_i[`CTL_RUN_BIT] && !reg_wdata_i[`CTL_ESTOP_BIT] &&
                      counts_ok && !home_block) begin
                     state        <= ST_RUN;
                     run_reverse  <= wr_rev_first;
                     second_leg   <= 1'b0;
                     steps_left   <= wr_rev_first ? reverse_step_count
                                                  : forward_step_count;
                     prescale_run <= wr_pw[`PW_PRESCALE_HI:`PW_PRESCALE_LO];
                     tgt_units    <= width_units(wr_pw);
                     cur_units    <= ramp_enable_i ? `MAX_UNITS
                                                   : width_units(wr_pw);
                     timer_load   <= 1'b1;
                     phase_o      <= `FIRST_PHASE;
                     motor_reverse_o <= wr_rev_first;
                     motor_running_o <= 1'b1;
                  end
               end
            end
            ST_RUN, ST_DECEL: begin
               // direction, home bits and repeated starts ignored
               if (ctl_wr && !reg_wdata_i[`CTL_RUN_BIT] && state == ST_RUN) begin
                  if (ramp_enable_i) begin
                     state     <= ST_DECEL;
                     tgt_units <= `MAX_UNITS;
                  end else begin
                     state           <= ST_IDLE;
                     phase_o         <= `RST_PHASE;
                     motor_running_o <= 1'b0;
                  end
               end else if (ctl_wr && reg_wdata_i[`CTL_RUN_BIT] &&
                            reg_wdata_i[`CTL_RESTART_BIT] && state == ST_RUN) begin
                  restart_pend <= 1'b1;
               end
               if (phase_done) begin
                  phase_o <= run_reverse ? {phase_o[0], phase_o[3:1]}
                                         : {phase_o[2:0], phase_o[3]};
                  cur_units <= ramp_toward(cur_units, tgt_units);
                  if (state == ST_RUN) begin
                     steps_left <= steps_left - 16'h0001;
                  end
                  if (restart_pend && state == ST_RUN) begin
                     restart_pend <= ctl_wr && reg_wdata_i[`CTL_RUN_BIT] &&
                                     reg_wdata_i[`CTL_RESTART_BIT];
                     tgt_units    <= width_units(run_pw);
                     if (!ramp_enable_i) begin
                        cur_units <= width_units(run_pw);
                     end
                  end
                  if (state == ST_DECEL && cur_units == `MAX_UNITS) begin
                     state           <= ST_IDLE;
                     phase_o         <= `RST_PHASE;
                     motor_running_o <= 1'b0;
                  end else if (state == ST_RUN && home_reached) begin
                     state           <= ST_IDLE;
                     phase_o         <= `RST_PHASE;
                     motor_running_o <= 1'b0;
                  end else if (state == ST_RUN && last_step) begin
                     if (reverse_leg_next) begin
                        second_leg      <= 1'b1;
                        run_reverse     <= !run_reverse;
                        motor_reverse_o <= !run_reverse;
                        steps_left      <= other_count;
                        prescale_run    <= other_pw[`PW_PRESCALE_HI:`PW_PRESCALE_LO];
                        tgt_units       <= width_units(other_pw);
                        cur_units       <= ramp_enable_i ? `MAX_UNITS
                                                         : width_units(other_pw);
                     end else begin
                        state           <= ST_IDLE;
                        phase_o         <= `RST_PHASE;
                        motor_running_o <= 1'b0;
                     end
                  end
               end
               if (ctl_wr && reg_wdata_i[`CTL_ESTOP_BIT]) begin
                  state           <= ST_IDLE;
                  phase_o         <= `RST_PHASE;
                  motor_running_o <= 1'b0;
                  restart_pend    <= 1'b0;
               end
            end
            default: begin
               state           <= ST_IDLE;
               phase_o         <= `RST_PHASE;
               motor_running_o <= 1'b0;
            end
         endcase
         if (state == ST_IDLE) begin
            restart_pend <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= `RST_BYTE;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `OFS_FWD_COUNT_LOW:  reg_rdata_o <= forward_step_count[7:0];
            `OFS_FWD_COUNT_HIGH: reg_rdata_o <= forward_step_count[15:8];
            `OFS_REV_COUNT_LOW:  reg_rdata_o <= reverse_step_count[7:0];
            `OFS_REV_COUNT_HIGH: reg_rdata_o <= reverse_step_count[15:8];
            `OFS_FWD_PW_LOW:     reg_rdata_o <= forward_pulse_width[7:0];
            `OFS_FWD_PW_HIGH:    reg_rdata_o <= forward_pulse_width[15:8];
            `OFS_REV_PW_LOW:     reg_rdata_o <= reverse_pulse_width[7:0];
            `OFS_REV_PW_HIGH:    reg_rdata_o <= reverse_pulse_width[15:8];
            `OFS_RUN_CONTROL:    reg_rdata_o <= {running, restart_pend, 4'h0, dir_sel};
            default:             reg_rdata_o <= `RST_BYTE;
         endcase
      end
   end

endmodule

// ===== testbench/stepper_run_control_checker.sv
/*
 checker for the stepper run control block, bound to its top module.
 assumes one clock and an asynchronous active-high reset.
*/
`include "stepper_defines.vh"

module stepper_run_control_checker (
   input wire       clk_i,
   input wire       sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire       reg_wr_i,
   input wire       reg_rd_i,
   input wire       ramp_enable_i,
   input wire [7:0] reg_rdata_o,
   input wire [3:0] phase_o,
   input wire       motor_running_o,
   input wire       motor_reverse_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // -------------
   // phase history
   // -------------
   logic [3:0]  prev_ph;
   logic [15:0] cnt;
   wire         step = prev_ph != 4'h0 && phase_o != 4'h0 && phase_o != prev_ph;
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prev_ph <= 4'h0;
         cnt     <= 16'h0000;
      end else begin
         prev_ph <= phase_o;
         if (phase_o != prev_ph) begin
            cnt <= 16'h0000;
         end else if (cnt != 16'hffff) begin
            cnt <= cnt + 16'h0001;
         end
      end
   end
   // -------------
   // assertions
   // -------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_run_wr;
      motor_running_o && reg_wr_i && reg_addr_i == `OFS_RUN_CONTROL;
   endsequence
   sequence s_ctl_rd;
      reg_rd_i && reg_addr_i == `OFS_RUN_CONTROL;
   endsequence
   a_phase_shape: assert property (motor_running_o ? $onehot(phase_o) : phase_o == 4'h0)
      else $error("phase lines disagree with run state");
   a_start_cause: assert property ($rose(motor_running_o) |-> phase_o == 4'h1
      && $past(reg_wr_i) && $past(reg_addr_i) == `OFS_RUN_CONTROL && $past(reg_wdata_i[7]))
      else $error("run began without a start write");
   a_estop_halts: assert property (s_run_wr ##0 reg_wdata_i[5] |=> phase_o == 4'h0)
      else $error("emergency stop did not halt");
   a_normal_stop: assert property (s_run_wr ##0 (!reg_wdata_i[7] && !ramp_enable_i)
      |=> !motor_running_o)
      else $error("normal stop did not halt");
   a_start_ignored: assert property (s_run_wr ##0 (reg_wdata_i[7:5] == 3'h4 && cnt < 16'd20)
      |=> motor_running_o && $stable(motor_reverse_o))
      else $error("start during run changed the run");
   a_ctl_readback: assert property (s_ctl_rd |=> reg_rdata_o[7] == $past(motor_running_o)
      && reg_rdata_o[5:2] == 4'h0)
      else $error("control readback wrong");
   a_fwd_rotate: assert property (step && !motor_reverse_o && !$past(motor_reverse_o)
      |-> phase_o == {prev_ph[2:0], prev_ph[3]})
      else $error("forward rotation wrong");
   a_rev_rotate: assert property (step && motor_reverse_o && $past(motor_reverse_o)
      |-> phase_o == {prev_ph[0], prev_ph[3:1]})
      else $error("reverse rotation wrong");
   a_min_period: assert property (step |-> cnt >= 16'd29)
      else $error("phase shorter than one base unit");
endmodule

bind stepper_run_control stepper_run_control_checker u_stepper_run_control_checker (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .ramp_enable_i(ramp_enable_i), .reg_rdata_o(reg_rdata_o), .phase_o(phase_o),
   .motor_running_o(motor_running_o), .motor_reverse_o(motor_reverse_o));

// ===== testbench/coil_driver_model.sv
/*
 coil driver stand-in: counts the phases of each run and measures
 the length of the last whole phase in clocks.
 assumes phase lines change only at rising clock edges.
*/
module coil_driver_model (
   input  wire       clk_i,
   input  wire [3:0] phase_i,
   output int        steps_o,
   output int        period_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] last = 4'h0;
   int         age  = 0;
   // -----------
   // phase watch
   // -----------
   always @(posedge clk_i) begin
      last <= phase_i;
      age  <= age + 1;
      if (phase_i != last && phase_i != 4'h0) begin
         steps_o <= (last == 4'h0) ? 1 : steps_o + 1;
         age     <= 1;
         if (last != 4'h0) begin
            period_o <= age;
         end
      end
   end
endmodule

// ===== testbench/stepper_run_control_tb.sv
/*
 testbench for the stepper run control block: registers, all direction
 modes, stops, restart and home gating.
 assumes the bound checker and the coil driver model.
*/
module stepper_run_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic WR = 1'b1;
   localparam logic RD = 1'b0;
   logic        clk_i      = 1'b0;
   logic        sys_rst_i  = 1'b1;
   logic [7:0]  addr       = 8'h00;
   logic [7:0]  wdata      = 8'h00;
   logic        wstb       = 1'b0;
   logic        rstb       = 1'b0;
   logic        home       = 1'b0;
   logic        ramp       = 1'b0;
   wire  [7:0]  rdata;
   wire  [3:0]  phase;
   wire         run;
   wire         rev;
   int          steps;
   int          period;
   int          n_mismatch = 0;
   int          n_checks   = 0;
   int          cyc        = 0;
   logic [15:0] cfg [7]    = '{16'h1203, 16'h1403, 16'h1500, 16'h1601,
                               16'h1700, 16'h1800, 16'h1920};
   always #50 clk_i = ~clk_i;
   stepper_run_control u_stepper_run_control (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wstb), .reg_rd_i(rstb), .home_sense_input_i(home), .ramp_enable_i(ramp),
      .reg_rdata_o(rdata), .phase_o(phase), .motor_running_o(run), .motor_reverse_o(rev));
   coil_driver_model u_coil_driver_model (
      .clk_i(clk_i), .phase_i(phase), .steps_o(steps), .period_o(period));
   // -----
   // tasks
   // -----
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr  <= a;
      wdata <= d;
      wstb  <= w;
      rstb  <= !w;
      @(posedge clk_i);
      wstb <= 1'b0;
      rstb <= 1'b0;
      #1;
      if (!w) chk({8'h00, rdata}, {8'h00, d});
   endtask
   task automatic idle(input int limit);
      for (int i = 0; i < limit && run === 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk({15'h0000, run}, 16'h0000);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // -------------
   // test sequence
   // -------------
   initial begin
      int a;
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (a = 8'h12; a <= 8'h1a; a++) acc(RD, a[7:0], 8'h00);
      acc(RD, 8'h20, 8'h00);
      for (a = 8'h14; a <= 8'h19; a++) begin
         acc(WR, a[7:0], a[7:0] ^ 8'h5a);
         acc(RD, a[7:0], a[7:0] ^ 8'h5a);
      end
      acc(WR, 8'h1a, 8'h80);
      acc(RD, 8'h1a, 8'h00);
      foreach (cfg[i]) acc(WR, cfg[i][15:8], cfg[i][7:0]);
      for (a = 0; a < 4; a++) begin
         acc(WR, 8'h1a, 8'h80 | a[7:0]);
         chk({run, rev, 10'h000, phase}, {1'b1, a[0], 10'h000, 4'h1});
         acc(RD, 8'h1a, 8'h80 | a[7:0]);
         acc(WR, 8'h1a, 8'h81 ^ a[7:0]);
         chk({15'h0000, rev}, {15'h0000, a[0]});
         idle(1000);
         chk(steps[15:0], a < 2 ? 16'd3 : 16'd6);
         chk(period[15:0], 16'd60);
      end
      acc(WR, 8'h1a, 8'h80);
      acc(WR, 8'h1a, 8'h20);
      chk({11'h000, run, phase}, 16'h0000);
      acc(RD, 8'h1a, 8'h00);
      acc(WR, 8'h1a, 8'h80);
      acc(WR, 8'h1a, 8'h00);
      chk({11'h000, run, phase}, 16'h0000);
      @(posedge clk_i);
      ramp <= 1'b1;
      acc(WR, 8'h1a, 8'h80);
      acc(WR, 8'h1a, 8'h00);
      chk({15'h0000, run}, 16'h0001);
      acc(WR, 8'h1a, 8'h20);
      chk({11'h000, run, phase}, 16'h0000);
      @(posedge clk_i);
      ramp <= 1'b0;
      acc(WR, 8'h12, 8'h20);
      acc(WR, 8'h1a, 8'h80);
      acc(WR, 8'h16, 8'h03);
      acc(WR, 8'h1a, 8'hc0);
      acc(RD, 8'h1a, 8'hc0);
      repeat (400) @(posedge clk_i);
      chk(period[15:0], 16'd120);
      acc(RD, 8'h1a, 8'h80);
      acc(WR, 8'h1a, 8'h20);
      acc(WR, 8'h16, 8'h01);
      acc(WR, 8'h1a, 8'h90);
      acc(RD, 8'h1a, 8'h00);
      acc(WR, 8'h1a, 8'h98);
      chk({15'h0000, run}, 16'h0001);
      @(posedge clk_i);
      home <= 1'b1;
      idle(100);
      tally_and_finish();
   end
endmodule
